// File: ptc_consts.vh
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH

// Register indices as printed (not multiples of four)
`define PTC_IDX_GAIN        12'h401
`define PTC_IDX_SERIAL      12'h432
`define PTC_IDX_DELAY       12'h446
// Byte address is index times four
`define PTC_ADDR_GAIN       14'h1004
`define PTC_ADDR_SERIAL     14'h10C8
`define PTC_ADDR_DELAY      14'h1118
`define PTC_ADDR_W          14

// Field layouts
`define PTC_GAIN_LSB        0
`define PTC_GAIN_MSB        3
`define PTC_GAIN_RST        4'hA
`define PTC_GAIN_UNITY      4'h8
`define PTC_GAIN_STEP_PCT   2
`define PTC_SER_TYPE_BIT    14
`define PTC_SER_RSVD_MSB    13
`define PTC_SER_TYPE_RST    1'h0
`define PTC_DLY_TX_LSB      4
`define PTC_DLY_TX_MSB      7
`define PTC_DLY_RX_LSB      0
`define PTC_DLY_RX_MSB      3
`define PTC_DLY_RST         4'h7
`define PTC_DLY_STEP_PS     24'h0000FA
`define PTC_DLY_RST_PS      12'h7D0
`define PTC_GAIN_PCT_RST    6'h04
`define PTC_RSVD_RST        16'h0000

// Serial interface variants
`define PTC_SER_FOUR_WIRE   1'h0
`define PTC_SER_SIX_WIRE    1'h1

`endif

// File: ptc_field_reg.v
`timescale 1ns/1ps
// One read-write field with synchronous reset
module ptc_field_reg #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             writeEn,
  input  wire [WIDTH-1:0] writeData,
  output reg  [WIDTH-1:0] value
);

  // Load on a completed write only
  always @(posedge clk)
  begin
    if (rst)
      value <= RESET_VALUE;
    else if (writeEn)
      value <= writeData;
  end

endmodule // ptc_field_reg

// File: ptc_delay_calc.v
`timescale 1ns/1ps
`include "ptc_consts.vh"
// Converts a delay code to picoseconds: (code+1) steps
module ptc_delay_calc #(
  parameter CODE_W = 4
) (
  input  wire              clk,
  input  wire              rst,
  input  wire [CODE_W-1:0] code,
  output reg  [11:0]       delayPs
);

  wire [CODE_W:0] steps;
  wire [23:0]     product;

  assign steps   = {1'b0, code} + {{CODE_W{1'b0}}, 1'b1};
  // Widened on purpose so the product keeps all 24 bits
  assign product = {{(23-CODE_W){1'b0}}, steps} * `PTC_DLY_STEP_PS;

  // Registered so the analog side sees a clean value
  always @(posedge clk)
  begin
    if (rst)
      delayPs <= `PTC_DLY_RST_PS;
    else
      delayPs <= product[11:0];
  end

endmodule // ptc_delay_calc

// File: ptc_tuning_regs.v
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "ptc_consts.vh"
module ptc_tuning_regs (
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire [3:0]  driverGainTrim,
  output reg  [5:0]  driverGainPctMag,
  output reg         driverGainNegative,
  output wire        serialSixWire,
  output wire        serialRxClockEnable,
  output wire [3:0]  txClockDelayCode,
  output wire [3:0]  rxClockDelayCode,
  output wire [11:0] txClockDelayPs,
  output wire [11:0] rxClockDelayPs
);

  wire                      accessPhase;
  wire                      writeStrobe;
  wire                      hitGain;
  wire                      hitSerial;
  wire                      hitDelay;
  wire                      hitAny;
  wire [`PTC_ADDR_W-1:0]    wordAddr;
  wire [0:0]                serialType;
  reg  [31:0]               next_prdata;
  reg  [5:0]                next_gainPctMag;
  reg                       next_gainNegative;
  reg  [31:0]               gainWord;
  reg  [31:0]               serialWord;
  reg  [31:0]               delayWord;
  wire                      gainWe;
  wire                      serialWe;
  wire                      delayWe;

  // Zero wait states: every access completes in its first access cycle
  assign accessPhase = psel & penable;
  assign pready      = 1'b1;
  assign wordAddr    = paddr[`PTC_ADDR_W-1:0];
  // Only the three mapped words answer; upper address bits must be zero
  assign hitGain     = (wordAddr == `PTC_ADDR_GAIN) &&
                       (paddr[31:`PTC_ADDR_W] == 18'h00000);
  assign hitSerial   = (wordAddr == `PTC_ADDR_SERIAL) &&
                       (paddr[31:`PTC_ADDR_W] == 18'h00000);
  assign hitDelay    = (wordAddr == `PTC_ADDR_DELAY) &&
                       (paddr[31:`PTC_ADDR_W] == 18'h00000);
  assign hitAny      = hitGain | hitSerial | hitDelay;
  // Unmapped addresses answer with an error and change nothing
  assign pslverr     = accessPhase & ~hitAny;
  assign writeStrobe = accessPhase & pwrite;

  // One write enable per register, taken in the access cycle
  assign gainWe      = writeStrobe & hitGain;
  assign serialWe    = writeStrobe & hitSerial;
  assign delayWe     = writeStrobe & hitDelay;

  // Gain trim field; upper bits have no storage
  ptc_field_reg #(
    .WIDTH       (4),
    .RESET_VALUE (`PTC_GAIN_RST)
  ) uGain (
    .clk       (clk),
    .rst       (rst),
    .writeEn   (gainWe),
    .writeData (pwdata[`PTC_GAIN_MSB:`PTC_GAIN_LSB]),
    .value     (driverGainTrim)
  );

  // Serial interface type select
  ptc_field_reg #(
    .WIDTH       (1),
    .RESET_VALUE (`PTC_SER_TYPE_RST)
  ) uSerial (
    .clk       (clk),
    .rst       (rst),
    .writeEn   (serialWe),
    .writeData (pwdata[`PTC_SER_TYPE_BIT]),
    .value     (serialType)
  );

  // Transmit clock delay code
  ptc_field_reg #(
    .WIDTH       (4),
    .RESET_VALUE (`PTC_DLY_RST)
  ) uTxDelay (
    .clk       (clk),
    .rst       (rst),
    .writeEn   (delayWe),
    .writeData (pwdata[`PTC_DLY_TX_MSB:`PTC_DLY_TX_LSB]),
    .value     (txClockDelayCode)
  );

  // Receive clock delay code
  ptc_field_reg #(
    .WIDTH       (4),
    .RESET_VALUE (`PTC_DLY_RST)
  ) uRxDelay (
    .clk       (clk),
    .rst       (rst),
    .writeEn   (delayWe),
    .writeData (pwdata[`PTC_DLY_RX_MSB:`PTC_DLY_RX_LSB]),
    .value     (rxClockDelayCode)
  );

  // Six-wire mode also turns on the differential receive clock pair
  assign serialSixWire       = (serialType == `PTC_SER_SIX_WIRE);
  assign serialRxClockEnable = serialSixWire;

  // Delay lines get picosecond values, (code+1)*250
  ptc_delay_calc #(
    .CODE_W (4)
  ) uTxCalc (
    .clk     (clk),
    .rst     (rst),
    .code    (txClockDelayCode),
    .delayPs (txClockDelayPs)
  );

  ptc_delay_calc #(
    .CODE_W (4)
  ) uRxCalc (
    .clk     (clk),
    .rst     (rst),
    .code    (rxClockDelayCode),
    .delayPs (rxClockDelayPs)
  );

  // Trim code to signed gain change, 2 percent per code step
  // A full table keeps every code explicit for the analog side
  always @*
  begin
    next_gainPctMag   = 6'h00;
    next_gainNegative = 1'b0;
    case (driverGainTrim)
      // Codes below unity cut gain
      4'h0:
      begin
        next_gainPctMag   = 6'h10;
        next_gainNegative = 1'b1;
      end
      4'h1:
      begin
        next_gainPctMag   = 6'h0E;
        next_gainNegative = 1'b1;
      end
      4'h2:
      begin
        next_gainPctMag   = 6'h0C;
        next_gainNegative = 1'b1;
      end
      4'h3:
      begin
        next_gainPctMag   = 6'h0A;
        next_gainNegative = 1'b1;
      end
      4'h4:
      begin
        next_gainPctMag   = 6'h08;
        next_gainNegative = 1'b1;
      end
      4'h5:
      begin
        next_gainPctMag   = 6'h06;
        next_gainNegative = 1'b1;
      end
      4'h6:
      begin
        next_gainPctMag   = 6'h04;
        next_gainNegative = 1'b1;
      end
      4'h7:
      begin
        next_gainPctMag   = 6'h02;
        next_gainNegative = 1'b1;
      end

      // Unity: no change in gain
      4'h8:
      begin
        next_gainPctMag   = 6'h00;
        next_gainNegative = 1'b0;
      end

      // Codes above unity raise gain
      4'h9:
      begin
        next_gainPctMag   = 6'h02;
        next_gainNegative = 1'b0;
      end
      4'hA:
      begin
        next_gainPctMag   = 6'h04;
        next_gainNegative = 1'b0;
      end
      4'hB:
      begin
        next_gainPctMag   = 6'h06;
        next_gainNegative = 1'b0;
      end
      4'hC:
      begin
        next_gainPctMag   = 6'h08;
        next_gainNegative = 1'b0;
      end
      4'hD:
      begin
        next_gainPctMag   = 6'h0A;
        next_gainNegative = 1'b0;
      end
      4'hE:
      begin
        next_gainPctMag   = 6'h0C;
        next_gainNegative = 1'b0;
      end
      4'hF:
      begin
        next_gainPctMag   = 6'h0E;
        next_gainNegative = 1'b0;
      end
      default:
      begin
        next_gainPctMag   = 6'h00;
        next_gainNegative = 1'b0;
      end
    endcase
  end

  // Registered so the driver sees a glitch-free setting
  // Reset value matches the trim reset code of 1010
  always @(posedge clk)
  begin
    if (rst)
    begin
      driverGainPctMag   <= `PTC_GAIN_PCT_RST;
      driverGainNegative <= 1'b0;
    end
    else
    begin
      driverGainPctMag   <= next_gainPctMag;
      driverGainNegative <= next_gainNegative;
    end
  end

  // Gain word: trim in the low nibble, the rest reads zero
  always @*
  begin
    gainWord = 32'h00000000;
    gainWord[`PTC_GAIN_MSB:`PTC_GAIN_LSB] = driverGainTrim;
  end

  // Serial word: only the type bit has storage
  always @*
  begin
    serialWord = 32'h00000000;
    serialWord[`PTC_SER_TYPE_BIT] = serialType[0];
  end

  // Delay word: both delay codes in the low byte
  always @*
  begin
    delayWord = 32'h00000000;
    delayWord[`PTC_DLY_TX_MSB:`PTC_DLY_TX_LSB] = txClockDelayCode;
    delayWord[`PTC_DLY_RX_MSB:`PTC_DLY_RX_LSB] = rxClockDelayCode;
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    next_prdata = 32'h00000000;
    if (hitGain)
      next_prdata = gainWord;
    else if (hitSerial)
      next_prdata = serialWord;
    else if (hitDelay)
      next_prdata = delayWord;
  end

  // Read data captured in setup so it stands through the access cycle
  // Capturing early lets pready stay high with no wait state
  always @(posedge clk)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
      prdata <= next_prdata;
  end

endmodule // ptc_tuning_regs

// File: ptc_tuning_regs_asserts.sv
`timescale 1ns/1ps
`include "ptc_consts.vh"
// Port-level watch on the tuning register bank
module ptc_regs_chk (
  input logic        clk,
  input logic        rst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic [3:0]  driverGainTrim,
  input logic        driverGainNegative,
  input logic        serialSixWire,
  input logic        serialRxClockEnable,
  input logic [3:0]  txClockDelayCode,
  input logic [3:0]  rxClockDelayCode,
  input logic [11:0] txClockDelayPs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Access phases of interest
  sequence wrGain;
    psel && penable && pwrite && paddr == `PTC_ADDR_GAIN;
  endsequence
  sequence wrDly;
    psel && penable && pwrite && paddr == `PTC_ADDR_DELAY;
  endsequence
  sequence rdSer;
    psel && penable && !pwrite && paddr == `PTC_ADDR_SERIAL;
  endsequence
  gain_wr_a:
    assert property (wrGain |=> driverGainTrim == $past(pwdata[3:0]))
    else $error("gain trim not written");
  gain_sign_a:
    assert property ($stable(driverGainTrim) |->
      driverGainNegative == (driverGainTrim < 4'h8))
    else $error("gain sign wrong");
  rx_pair_a:
    assert property (serialRxClockEnable == serialSixWire)
    else $error("rx clock pair mismatch");
  dly_wr_a:
    assert property (wrDly |=>
      {txClockDelayCode, rxClockDelayCode} == $past(pwdata[7:0]))
    else $error("delay codes not written");
  tx_ps_a:
    assert property (txClockDelayPs ==
      ($past(txClockDelayCode) + 12'h001) * 12'h0FA)
    else $error("tx delay ps wrong");
  rsvd_rd_a:
    assert property (rdSer |-> prdata[31:15] == 17'h0 && prdata[13:0] == 14'h0)
    else $error("reserved bits not zero");
endmodule // ptc_regs_chk

bind ptc_tuning_regs ptc_regs_chk chk (.*);

// File: ptc_mac_model.sv
`timescale 1ns/1ps
// Far-end MAC: lanes it expects from the serial mode outputs
module ptc_mac_model (
  input  logic       sixWire,
  input  logic       rxClockEnable,
  output logic [3:0] laneCount
);
  // Six lanes only if the receive clock pair is driven too
  assign laneCount = (sixWire && rxClockEnable) ? 4'h6 : 4'h4;
endmodule // ptc_mac_model

// File: ptc_tuning_regs_tb.sv
`timescale 1ns/1ps
`include "ptc_consts.vh"
module ptc_tuning_regs_tb;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        driverGainNegative, serialSixWire, serialRxClockEnable;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  driverGainTrim, txClockDelayCode, rxClockDelayCode, lanes;
  logic [5:0]  driverGainPctMag;
  logic [11:0] txClockDelayPs, rxClockDelayPs;
  int          n_fail = 0;
  int          n_checks = 0;

  ptc_tuning_regs dut (.*);
  ptc_mac_model mac (.sixWire(serialSixWire),
    .rxClockEnable(serialRxClockEnable), .laneCount(lanes));
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; the wait on pready is bounded
  task automatic apb(input logic w, input logic [31:0] a, d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    if (i == 16)
    begin
      n_fail++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Let field and picosecond outputs land
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    apb(1'b0, `PTC_ADDR_GAIN, 32'h0);
    chk("gain", 32'hA, rd);
    apb(1'b0, `PTC_ADDR_SERIAL, 32'h0);
    chk("serial", 32'h0, rd);
    apb(1'b0, `PTC_ADDR_DELAY, 32'h0);
    chk("delay", 32'h77, rd);
    chk("txps", 32'h7D0, {20'h0, txClockDelayPs});
    $display("reset done");
  endtask
  task automatic t_gain();
    logic [3:0] cs [3] = '{4'h0, 4'h8, 4'hF};
    foreach (cs[k])
    begin
      apb(1'b1, `PTC_ADDR_GAIN, {28'h0, cs[k]});
      settle();
      apb(1'b0, `PTC_ADDR_GAIN, 32'h0);
      chk("gain", {28'h0, cs[k]}, rd);
      chk("trim", {28'h0, cs[k]}, {28'h0, driverGainTrim});
      chk("neg", {31'h0, cs[k] < 4'h8}, {31'h0, driverGainNegative});
      chk("pct", cs[k] < 4'h8 ? 32'h10 - 32'h2 * cs[k]
        : 32'h2 * cs[k] - 32'h10, {26'h0, driverGainPctMag});
    end
    $display("gain done");
  endtask
  // Ones into reserved bits must not stick
  task automatic t_serial();
    for (int v = 1; v >= 0; v--)
    begin
      apb(1'b1, `PTC_ADDR_SERIAL, v ? 32'hFFFFFFFF : 32'h0);
      settle();
      apb(1'b0, `PTC_ADDR_SERIAL, 32'h0);
      chk("serial", v ? 32'h4000 : 32'h0, rd);
      chk("lanes", v ? 32'h6 : 32'h4, {28'h0, lanes});
    end
    $display("serial done");
  endtask
  task automatic t_delay();
    logic [7:0] ds [2] = '{8'h0F, 8'hF0};
    foreach (ds[k])
    begin
      apb(1'b1, `PTC_ADDR_DELAY, {24'hFFFFFF, ds[k]});
      settle();
      apb(1'b0, `PTC_ADDR_DELAY, 32'h0);
      chk("delay", {24'h0, ds[k]}, rd);
      chk("codes", {24'h0, ds[k]},
        {24'h0, txClockDelayCode, rxClockDelayCode});
      chk("txps", (ds[k][7:4] + 32'h1) * 32'hFA, txClockDelayPs);
      chk("rxps", (ds[k][3:0] + 32'h1) * 32'hFA, rxClockDelayPs);
    end
    apb(1'b0, 32'h1008, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped rd", 32'h0, rd);
    $display("delay done");
  endtask
  // Reset, then the scenarios
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_gain();
    t_serial();
    t_delay();
    close_out();
  end
endmodule // ptc_tuning_regs_tb
